// >>> logic/rtam_alarm_match.sv
// Module: time-of-day alarm register, compare logic and APB slave
//
// Chosen here: the APB register port.
module rtam_alarm_match
    import rtam_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire rtam_time_s  curTime,
    output logic             alarmEvent,
    output logic             irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [31:0]      timeAlarm_reg;
    logic [31:0]      timeAlarm_next;
    logic             writeLock_reg;
    logic             writeLock_next;
    logic [EVT_W-1:0] evtMask_reg;
    logic [EVT_W-1:0] evtMask_next;
    rtam_apb_rsp_s    rsp_reg;
    rtam_apb_rsp_s    rsp_next;
    logic             matchPrev_reg;
    logic             matchPrev_next;
    logic             alarmEvent_reg;
    logic             alarmEvent_next;
    logic             irq_reg;
    logic             irq_next;

    logic             accessEnd;
    logic             wrEnd;
    logic             rdEnd;
    logic             hitAlarm;
    logic             hitLock;
    logic             hitStatus;
    logic             hitMask;
    logic             mapped;
    logic             lockedWrite;
    logic             ssEn;
    logic             mmEn;
    logic             hhEn;
    logic             ssHit;
    logic             mmHit;
    logic             hhHit;
    logic             anyEn;
    logic             matchNow;
    logic [EVT_W-1:0] evtStatus;
    logic             statusClear;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // Transfer completes on the edge where pready is already high
    assign accessEnd = psel && penable && rsp_reg.ready;
    assign wrEnd     = accessEnd && pwrite;
    assign rdEnd     = accessEnd && !pwrite;

    // Address decoding
    always_comb begin
        hitAlarm  = 1'b0;
        hitLock   = 1'b0;
        hitStatus = 1'b0;
        hitMask   = 1'b0;
        if (paddr == ADDR_TIME_ALARM) begin
            hitAlarm = 1'b1;
        end else if (paddr == ADDR_LOCK_MODE) begin
            hitLock = 1'b1;
        end else if (paddr == ADDR_EVT_STATUS) begin
            hitStatus = 1'b1;
        end else if (paddr == ADDR_EVT_MASK) begin
            hitMask = 1'b1;
        end
    end

    assign mapped      = hitAlarm || hitLock || hitStatus || hitMask;
    assign lockedWrite = wrEnd && hitAlarm && writeLock_reg;
    assign statusClear = rdEnd && hitStatus;

    // ------------------------------------------------------------
    // Field compare
    // ------------------------------------------------------------
    assign ssEn = timeAlarm_reg[SS_EN_BIT];
    assign mmEn = timeAlarm_reg[MM_EN_BIT];
    assign hhEn = timeAlarm_reg[HH_EN_BIT];

    // Seconds field against seconds counter
    rtam_field_match #(
        .W (SS_W)
    ) u_ssMatch (
        .enable  (ssEn),
        .target  (timeAlarm_reg[SS_LSB +: SS_W]),
        .current (curTime.second),
        .hit     (ssHit)
    );

    // Minutes field against minutes counter
    rtam_field_match #(
        .W (MM_W)
    ) u_mmMatch (
        .enable  (mmEn),
        .target  (timeAlarm_reg[MM_LSB +: MM_W]),
        .current (curTime.minute),
        .hit     (mmHit)
    );

    // Hours plus half-day flag against hour counter
    rtam_field_match #(
        .W (HH_W + 1)
    ) u_hhMatch (
        .enable  (hhEn),
        .target  ({timeAlarm_reg[HALF_BIT],
                   timeAlarm_reg[HH_LSB +: HH_W]}),
        .current ({curTime.halfDayPm, curTime.hour}),
        .hit     (hhHit)
    );

    // Needs one enabled field and every enabled field equal
    assign anyEn    = ssEn || mmEn || hhEn;
    assign matchNow = anyEn && ssHit && mmHit && hhHit;

    // ------------------------------------------------------------
    // Event flags
    // ------------------------------------------------------------
    // Alarm event flag
    rtam_sticky_flag u_alarmFlag (
        .clock      (clock),
        .rst_n      (rst_n),
        .setPulse   (alarmEvent_next),
        .clearPulse (statusClear),
        .flag       (evtStatus[EVT_ALARM_BIT])
    );

    // Locked-write violation flag
    rtam_sticky_flag u_violFlag (
        .clock      (clock),
        .rst_n      (rst_n),
        .setPulse   (lockedWrite),
        .clearPulse (statusClear),
        .flag       (evtStatus[EVT_VIOL_BIT])
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Registers, bus answer, event and interrupt
    always_comb begin
        timeAlarm_next  = timeAlarm_reg;
        writeLock_next  = writeLock_reg;
        evtMask_next    = evtMask_reg;
        rsp_next        = rsp_reg;
        matchPrev_next  = matchNow;
        // Fire once when the compare becomes true
        alarmEvent_next = matchNow && !matchPrev_reg;
        irq_next        = |(evtStatus & evtMask_reg);

        if (wrEnd && hitAlarm && !writeLock_reg) begin
            timeAlarm_next = pwdata & ALARM_WMASK;
        end
        if (wrEnd && hitLock) begin
            writeLock_next = pwdata[LOCK_BIT];
        end
        if (wrEnd && hitMask) begin
            evtMask_next = pwdata[EVT_W-1:0];
        end

        // One wait state, then pready with data
        rsp_next.ready  = psel && penable && !rsp_reg.ready;
        rsp_next.slvErr = 1'b0;
        rsp_next.rdata  = 32'h0000_0000;
        if (psel && penable && !rsp_reg.ready) begin
            rsp_next.slvErr = !mapped;
            if (!pwrite) begin
                if (hitAlarm) begin
                    rsp_next.rdata = timeAlarm_reg;
                end else if (hitLock) begin
                    rsp_next.rdata = {31'h0, writeLock_reg};
                end else if (hitStatus) begin
                    rsp_next.rdata = {30'h0, evtStatus};
                end else if (hitMask) begin
                    rsp_next.rdata = {30'h0, evtMask_reg};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // State update
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timeAlarm_reg  <= ALARM_RESET;
            writeLock_reg  <= LOCK_RESET;
            evtMask_reg    <= MASK_RESET;
            rsp_reg        <= '0;
            matchPrev_reg  <= 1'b0;
            alarmEvent_reg <= 1'b0;
            irq_reg        <= 1'b0;
        end else begin
            timeAlarm_reg  <= timeAlarm_next;
            writeLock_reg  <= writeLock_next;
            evtMask_reg    <= evtMask_next;
            rsp_reg        <= rsp_next;
            matchPrev_reg  <= matchPrev_next;
            alarmEvent_reg <= alarmEvent_next;
            irq_reg        <= irq_next;
        end
    end

    assign prdata     = rsp_reg.rdata;
    assign pready     = rsp_reg.ready;
    assign pslverr    = rsp_reg.slvErr;
    assign alarmEvent = alarmEvent_reg;
    assign irq        = irq_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_lock_blocks: assert property (
        wrEnd && hitAlarm && writeLock_reg |=> $stable(timeAlarm_reg))
        else $error("Alarm register changed under write lock");

    a_write_taken: assert property (
        wrEnd && hitAlarm && !writeLock_reg
        |=> timeAlarm_reg == ($past(pwdata) & ALARM_WMASK))
        else $error("Unlocked alarm write not stored");

    a_sec_gate: assert property (
        ssEn && !mmEn && !hhEn && timeAlarm_reg[6:0] != curTime.second
        |-> !matchNow)
        else $error("Seconds mismatch still matched");

    a_min_gate: assert property (
        mmEn && timeAlarm_reg[14:8] != curTime.minute |-> !matchNow)
        else $error("Minutes mismatch still matched");

    a_hour_gate: assert property (
        hhEn && timeAlarm_reg[21:16] != curTime.hour |-> !matchNow)
        else $error("Hours mismatch still matched");

    a_sec_field: assert property (
        ssEn && !mmEn && !hhEn && timeAlarm_reg[6:0] == curTime.second
        |-> matchNow)
        else $error("Seconds equal but no match");

    a_min_field: assert property (
        wrEnd && hitAlarm && !writeLock_reg
        |=> timeAlarm_reg[14:8] == $past(pwdata[14:8]))
        else $error("Minutes target misplaced");

    a_half_day: assert property (
        hhEn && timeAlarm_reg[22] != curTime.halfDayPm |-> !matchNow)
        else $error("Half-day mismatch still matched");

    a_event_cause: assert property (
        alarmEvent_reg |-> $past(anyEn) && !$past(matchPrev_reg, 2) ##0 $past(matchNow))
        else $error("Alarm event without fresh match");

    a_none_enabled: assert property (
        !anyEn |=> !alarmEvent_reg)
        else $error("Alarm event with no field enabled");

    a_irq_follow: assert property (
        (evtStatus & evtMask_reg) != 2'h0 |=> irq_reg)
        else $error("Interrupt missing for unmasked flag");

    a_ready_wait: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("APB answer timing broken");

    c_alarm_fire:   cover property (alarmEvent_reg ##[1:20] irq_reg);
    c_locked_write: cover property (lockedWrite);
    c_status_read:  cover property (statusClear && evtStatus != 2'h0);
    c_bad_address:  cover property (pready && pslverr);

endmodule // rtam_alarm_match

// >>> logic/rtam_pkg.sv
// Package: constants and types for the time alarm compare block
package rtam_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_TIME_ALARM  = 32'h400e_1470;
    localparam logic [31:0] ADDR_LOCK_MODE   = 32'h400e_1480;
    localparam logic [31:0] ADDR_EVT_STATUS  = 32'h400e_1484;
    localparam logic [31:0] ADDR_EVT_MASK    = 32'h400e_1488;

    // ------------------------------------------------------------
    // Alarm register field layout
    // ------------------------------------------------------------
    localparam int SS_LSB      = 0;
    localparam int SS_W        = 7;
    localparam int SS_EN_BIT   = 7;
    localparam int MM_LSB      = 8;
    localparam int MM_W        = 7;
    localparam int MM_EN_BIT   = 15;
    localparam int HH_LSB      = 16;
    localparam int HH_W        = 6;
    localparam int HALF_BIT    = 22;
    localparam int HH_EN_BIT   = 23;

    localparam logic [31:0] ALARM_WMASK = 32'h00ff_ffff;
    localparam logic [31:0] ALARM_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // Lock mode, event status and mask layout
    // ------------------------------------------------------------
    localparam int LOCK_BIT      = 0;
    localparam int EVT_ALARM_BIT = 0;
    localparam int EVT_VIOL_BIT  = 1;
    localparam int EVT_W         = 2;
    localparam logic             LOCK_RESET = 1'b0;
    localparam logic [EVT_W-1:0] MASK_RESET = 2'h0;

    // Current time from the clock counters, BCD coded
    typedef struct packed {
        logic            halfDayPm;
        logic [HH_W-1:0] hour;
        logic [MM_W-1:0] minute;
        logic [SS_W-1:0] second;
    } rtam_time_s;

    // APB slave answer bundle
    typedef struct packed {
        logic        ready;
        logic        slvErr;
        logic [31:0] rdata;
    } rtam_apb_rsp_s;

endpackage : rtam_pkg

// >>> logic/rtam_field_match.sv
// Module: one BCD alarm field compare with its match enable
module rtam_field_match
    import rtam_pkg::*;
#(
    parameter int W = 7
) (
    input  wire logic         enable,
    input  wire logic [W-1:0] target,
    input  wire logic [W-1:0] current,
    output logic              hit
);

    // ------------------------------------------------------------
    // Disabled field never blocks the match
    // ------------------------------------------------------------
    assign hit = !enable || (target == current);

endmodule // rtam_field_match

// >>> logic/rtam_sticky_flag.sv
// Module: sticky event flag, set wins over clear-on-read
module rtam_sticky_flag
    import rtam_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic setPulse,
    input  wire logic clearPulse,
    output logic      flag
);

    logic flag_reg;
    logic flag_next;

    // Next value, set has priority
    always_comb begin
        flag_next = setPulse || (flag_reg && !clearPulse);
    end

    // Flag storage
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;

endmodule // rtam_sticky_flag

// >>> verification/rtam_alarm_match_tb_top.sv
// Testbench: APB-driven checks of the time alarm register and compare
module rtam_alarm_match_tb_top
    import rtam_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clock;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    rtam_time_s  curTime;
    logic        alarmEvent;
    logic        irq;
    logic [31:0] rdat;
    logic        rerr;
    int          error_cnt;
    int          cmp_count;
    int          evtCnt;
    int          base;
    int          cyc;

    // Device under test
    rtam_alarm_match rtam_alarm_match_inst (
        .clock      (clock),
        .rst_n      (rst_n),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .curTime    (curTime),
        .alarmEvent (alarmEvent),
        .irq        (irq)
    );

    // Clock source, 50 ns period
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Alarm pulse counter and hang guard
    always @(posedge clock) begin
        if (alarmEvent === 1'b1) evtCnt <= evtCnt + 1;
        cyc <= cyc + 1;
        if (cyc > 4000) begin
            error_cnt++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Tasks and helpers
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; holds the request until pready is sampled high or 20 cycles pass
    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wdat);
        int n;
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= addr;
        pwdata <= wdat;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] addr, input logic [31:0] d);
        apb(1'b1, addr, d);
    endtask

    task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check($sformatf("rd %h", addr), rdat, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Pulses seen since the last mark
    task automatic evts(input int exp);
        tick(4);
        check("alarm pulses", 32'(evtCnt - base), 32'(exp));
        base = evtCnt;
    endtask

    function automatic logic [31:0] alw(logic se, logic [6:0] s, logic me, logic [6:0] m,
                                        logic he, logic pm, logic [5:0] h);
        return {8'h00, he, pm, h, me, m, se, s};
    endfunction

    function automatic rtam_time_s tm(logic pm, logic [5:0] h, logic [6:0] m, logic [6:0] s);
        return {pm, h, m, s};
    endfunction

    task conclude;
        if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 32'h0; pwdata = 32'h0; curTime = tm(1'b0, 6'h11, 7'h22, 7'h33);
        error_cnt = 0; cmp_count = 0; evtCnt = 0; base = 0; cyc = 0;
        tick(10);
        rst_n <= 1'b1;
        // Reset values, unmapped access refused
        rd(ADDR_TIME_ALARM, ALARM_RESET);
        rd(ADDR_LOCK_MODE, 32'h0);
        rd(ADDR_EVT_MASK, 32'h0);
        rd(ADDR_EVT_STATUS, 32'h0);
        wr(32'h400e_1474, 32'hffff_ffff);
        check("pslverr", {31'h0, rerr}, 32'h1);
        rd(32'h400e_1474, 32'h0);
        check("pslverr", {31'h0, rerr}, 32'h1);
        // Seconds only, minutes target differs but disabled
        wr(ADDR_EVT_MASK, 32'h3);
        wr(ADDR_TIME_ALARM, alw(1, 7'h33, 0, 7'h00, 0, 0, 6'h00));
        evts(1);
        check("irq", {31'h0, irq}, 32'h1);
        rd(ADDR_EVT_STATUS, 32'h1);
        rd(ADDR_EVT_STATUS, 32'h0);
        tick(2);
        check("irq", {31'h0, irq}, 32'h0);
        // Minutes enabled with a differing target, then time reaches it
        wr(ADDR_TIME_ALARM, alw(1, 7'h33, 1, 7'h21, 0, 0, 6'h00));
        evts(0);
        curTime <= tm(1'b0, 6'h11, 7'h21, 7'h33);
        evts(1);
        // Hours with half-day flag
        wr(ADDR_TIME_ALARM, alw(1, 7'h33, 1, 7'h21, 1, 1, 6'h11));
        evts(0);
        curTime <= tm(1'b1, 6'h11, 7'h21, 7'h33);
        evts(1);
        curTime <= tm(1'b1, 6'h12, 7'h21, 7'h33);
        evts(0);
        // Change hour target: disable, write value, re-enable
        wr(ADDR_TIME_ALARM, alw(1, 7'h33, 1, 7'h21, 0, 1, 6'h11));
        wr(ADDR_TIME_ALARM, alw(1, 7'h33, 1, 7'h21, 0, 1, 6'h12));
        wr(ADDR_TIME_ALARM, alw(1, 7'h33, 1, 7'h21, 1, 1, 6'h12));
        evts(1);
        rd(ADDR_TIME_ALARM, alw(1, 7'h33, 1, 7'h21, 1, 1, 6'h12));
        rd(ADDR_EVT_STATUS, 32'h1);
        // No enables never fire; upper byte reads zero
        wr(ADDR_TIME_ALARM, 32'hff00_0033);
        evts(0);
        rd(ADDR_TIME_ALARM, 32'h0000_0033);
        // Write lock blocks alarm writes and flags the attempt
        wr(ADDR_LOCK_MODE, 32'h1);
        wr(ADDR_TIME_ALARM, 32'h0000_00b3);
        evts(0);
        rd(ADDR_TIME_ALARM, 32'h0000_0033);
        check("irq", {31'h0, irq}, 32'h1);
        rd(ADDR_EVT_STATUS, 32'h2);
        wr(ADDR_LOCK_MODE, 32'h0);
        wr(ADDR_TIME_ALARM, 32'h0000_00b3);
        evts(1);
        rd(ADDR_TIME_ALARM, 32'h0000_00b3);
        // Masked event keeps irq low but sets status
        wr(ADDR_EVT_STATUS, 32'h0);
        rd(ADDR_EVT_STATUS, 32'h1);
        wr(ADDR_EVT_MASK, 32'h0);
        curTime <= tm(1'b1, 6'h12, 7'h21, 7'h34);
        evts(0);
        curTime <= tm(1'b1, 6'h12, 7'h21, 7'h33);
        evts(1);
        check("irq", {31'h0, irq}, 32'h0);
        rd(ADDR_EVT_STATUS, 32'h1);
        // Second reset in mid-run
        @(posedge clock);
        rst_n <= 1'b0;
        tick(3);
        rst_n <= 1'b1;
        rd(ADDR_TIME_ALARM, ALARM_RESET);
        evts(0);
        conclude();
    end

endmodule // rtam_alarm_match_tb_top
